// [rtl/sfvc_host.sv]
// Purpose: Host end: issues settings and read commands over the link
// Assumes: i_clock 10 MHz; sck derived by divider; mode 0, MSB first
// Notes: Two-entry buffer holds returned bytes while the user stalls
`timescale 1ns/100ps
`include "sfvc_cfg.svh"
module sfvc_host (
	// System
	input wire logic i_clock,
	input wire logic i_rst,
	// Request
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire sfvc_pkg::sfvc_op_e i_req_op,
	input wire logic [23:0] i_req_addr,
	input wire logic [7:0] i_req_data,
	input wire logic [7:0] i_req_len,
	// Returned bytes
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [7:0] o_rd_data,
	// Link
	sfvc_link_if.host link
);
	typedef enum logic [1:0] {SFVC_H_IDLE, SFVC_H_SHIFT, SFVC_H_GAP} sfvc_hstate_e;

	sfvc_hstate_e state;
	logic [47:0] out_sr;
	logic [7:0] in_sr;
	logic [6:0] bits_left;
	logic [6:0] rx_start;
	logic rd_op;
	logic [7:0] bytes_left;
	logic [2:0] rx_bit;
	logic [1:0] div;
	logic sck;
	logic [7:0] buf_mem [0:1];
	logic buf_wp;
	logic buf_rp;
	logic [1:0] buf_cnt;
	logic push;
	logic pop;
	logic rise;
	logic fall;

	// Header bits for a request: command alone, or command plus address and dummies, or command plus write data
	function automatic logic [6:0] hdr_bits(input sfvc_pkg::sfvc_op_e op);
		case (op)
			sfvc_pkg::SFVC_OP_WRITE_VOL: return 7'h10;
			sfvc_pkg::SFVC_OP_FAST_READ: return 7'h28; // default 8 dummies [R8]
			default: return 7'h08;
		endcase
	endfunction : hdr_bits

	// A rise is held back while the buffer is full, so no returned byte is lost
	assign rise = (state == SFVC_H_SHIFT) && !sck && div == 2'(`SFVC_SCK_HALF_CYCLES - 1)
		&& !(rx_start != 7'h00 && buf_cnt == 2'h2);
	assign fall = (state == SFVC_H_SHIFT) && sck && div == 2'(`SFVC_SCK_HALF_CYCLES - 1);
	assign push = rise && bits_left <= rx_start && rx_bit == 3'h7;
	assign pop = o_rd_valid && i_rd_ready;
	assign o_req_ready = (state == SFVC_H_IDLE) && buf_cnt == 2'h0;
	assign o_rd_valid = buf_cnt != 2'h0;
	assign o_rd_data = buf_mem[buf_rp];

	// ----------------------------------------
	// Frame sequencer and clock divider
	// ----------------------------------------
	// Host passes write data unchecked, so dummy codes 0 and 1 can be set [R15]; sck stays low between frames
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			state <= SFVC_H_IDLE;
			div <= 2'h0;
			sck <= 1'b0;
			out_sr <= 48'h0;
			bits_left <= 7'h00;
			rx_start <= 7'h00;
			bytes_left <= 8'h00;
			rd_op <= 1'b0;
		end
		else
		begin
			case (state)
				SFVC_H_IDLE:
				begin
					if (i_req_valid && o_req_ready)
					begin
						state <= SFVC_H_SHIFT;
						bytes_left <= i_req_len;
						case (i_req_op)
							sfvc_pkg::SFVC_OP_READ_VOL:
								out_sr <= {`SFVC_CMD_READ_VOL, 40'h0}; // [R1]
							sfvc_pkg::SFVC_OP_WRITE_VOL:
								out_sr <= {`SFVC_CMD_WRITE_VOL, i_req_data, 32'h0}; // [R1]
							sfvc_pkg::SFVC_OP_FAST_READ:
								out_sr <= {`SFVC_CMD_FAST_READ, i_req_addr, 16'h0};
							default:
								out_sr <= {`SFVC_CMD_TUNING, 40'h0}; // [R12]
						endcase
						// Nothing is received during the header
						rx_start <= 7'h00;
						rd_op <= (i_req_op != sfvc_pkg::SFVC_OP_WRITE_VOL);
						bits_left <= hdr_bits(i_req_op);
					end
				end
				SFVC_H_SHIFT:
				begin
					// Divider rests at its last count while a rise is held back
					if (rise || fall)
					begin
						div <= 2'h0;
						sck <= !sck;
					end
					else if (div != 2'(`SFVC_SCK_HALF_CYCLES - 1))
						div <= div + 2'h1;
					if (fall)
					begin
						out_sr <= {out_sr[46:0], 1'b0};
						if (bits_left > 7'h01)
							bits_left <= bits_left - 7'h01;
						else if (rd_op && (rx_start == 7'h00 || bytes_left != 8'h00))
						begin
							// Header done or more bytes wanted: clock one more byte
							bits_left <= 7'h08;
							rx_start <= 7'h08;
							if (rx_start != 7'h00)
								bytes_left <= bytes_left - 8'h01;
						end
						else
							state <= SFVC_H_GAP;
					end
				end
				SFVC_H_GAP: state <= SFVC_H_IDLE;
				default: state <= SFVC_H_IDLE;
			endcase
		end
	end

	// Receive bit counter and shifter
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			in_sr <= 8'h00;
			rx_bit <= 3'h0;
		end
		else if (rise && bits_left <= rx_start)
		begin
			in_sr <= {in_sr[6:0], link.miso};
			rx_bit <= rx_bit + 3'h1;
		end
		else if (state == SFVC_H_IDLE)
			rx_bit <= 3'h0;
	end

	// ----------------------------------------
	// Two-entry return buffer
	// ----------------------------------------
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			buf_wp <= 1'b0;
			buf_rp <= 1'b0;
			buf_cnt <= 2'h0;
		end
		else
		begin
			if (push)
				buf_wp <= !buf_wp;
			if (pop)
				buf_rp <= !buf_rp;
			buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (push)
			buf_mem[buf_wp] <= {in_sr[6:0], link.miso};
	end

	assign link.sck = sck;
	assign link.cs_n = (state != SFVC_H_SHIFT);
	assign link.mosi = out_sr[47];
endmodule : sfvc_host

// [rtl/sfvc_cfg.svh]
// Purpose: Constants for the serial flash volatile settings link
// Assumes: Included by bare name from both ends and the bench
// Notes: Command codes, field positions, reset values and timing counts
`ifndef SFVC_CFG_SVH
`define SFVC_CFG_SVH

// ----------------------------------------
// Command codes (arbitrary encodings)
// ----------------------------------------
`define SFVC_CMD_READ_VOL 8'h85
`define SFVC_CMD_WRITE_VOL 8'h81
`define SFVC_CMD_FAST_READ 8'h0B
`define SFVC_CMD_TUNING 8'h5A

// ----------------------------------------
// Volatile settings fields
// ----------------------------------------
`define SFVC_DUMMY_MSB 7
`define SFVC_DUMMY_LSB 4
`define SFVC_XIP_BIT 3
`define SFVC_RSVD_BIT 2
`define SFVC_WRAP_MSB 1
`define SFVC_WRAP_LSB 0
`define SFVC_RSVD_MASK 8'hFB
`define SFVC_DUMMY_DEFAULT_CODE 4'hF
`define SFVC_WRAP_16 2'h0
`define SFVC_WRAP_32 2'h1
`define SFVC_WRAP_64 2'h2
`define SFVC_WRAP_CONT 2'h3

// ----------------------------------------
// Reset and nonvolatile defaults
// ----------------------------------------
`define SFVC_NONVOL_DEFAULT 8'hFB
`define SFVC_FAST_READ_DEFAULT_DUMMY 4'h8
`define SFVC_TUNING_PATTERN 8'h34

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFVC_CLK_PERIOD_NS 100
`define SFVC_SCK_HALF_DIV 2
`define SFVC_SCK_HALF_NS 200
`define SFVC_SCK_HALF_CYCLES (`SFVC_SCK_HALF_NS / `SFVC_CLK_PERIOD_NS)

`endif

// [rtl/sfvc_pkg.sv]
// Purpose: Shared types for the volatile settings link
// Assumes: sfvc_cfg.svh holds all numbers
// Notes: Types only
package sfvc_pkg;
	// Host request kinds
	typedef enum logic [1:0] {SFVC_OP_READ_VOL, SFVC_OP_WRITE_VOL, SFVC_OP_FAST_READ,
		SFVC_OP_TUNING} sfvc_op_e;
	typedef logic [23:0] sfvc_addr_t;
endpackage : sfvc_pkg

// [rtl/sfvc_link_if.sv]
// Purpose: Serial link between flash end and host end
// Assumes: Host drives clock and select; single data line each way
// Notes: Host owns sck, so device logic runs on it
`timescale 1ns/100ps
interface sfvc_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;

	// Host end
	modport host (output sck, output cs_n, output mosi, input miso, input miso_oe);
	// Flash end
	modport flash (input sck, input cs_n, input mosi, output miso, output miso_oe);
endinterface : sfvc_link_if

// [rtl/sfvc_flash.sv]
// Purpose: Flash end: volatile settings register, settings store, read data path
// Assumes: Link clock is the host sck; mode 0; MSB first; 24-bit address
// Notes: Array content is a stand-in pattern derived from the address
//
// How it works
// [R1] Dedicated commands read and write volatile settings
// [R2] Command end copies settings into settings store
// [R3] Bits 7:4 dummy count; 1111 default
// [R4] Bit 3 low enables execute in place
// [R5] Wrap codes 16, 32, 64 aligned blocks
// [R6] Code 11 reads sequentially, no wrap
// [R7] Wrap reaches block end, restarts at start
// [R8] Host programs dummy count for its clock
// [R9] Too few dummies gives invalid read data
// [R10] Grade clock limits versus dummy count
// [R11] Ultra grade quad clock capped at 108
// [R12] Tuning pattern helps host capture timing
// [R13] Reset reloads store from nonvolatile settings
// [R14] Reserved bit 2 reads zero, no effect
// [R15] Host avoids dummy codes 0000 and 0001; the host end does not check them
`timescale 1ns/100ps
`include "sfvc_cfg.svh"
module sfvc_flash (
	// Link
	sfvc_link_if.flash link,
	// System
	input wire logic i_rst,
	// Status on the link clock
	output logic [7:0] o_settings,
	output logic o_execute_in_place,
	output logic o_store_loaded
);
	typedef enum logic [2:0] {SFVC_F_CMD, SFVC_F_ADDR, SFVC_F_DUMMY, SFVC_F_WDATA,
		SFVC_F_RDATA, SFVC_F_IGNORE} sfvc_fstate_e;

	sfvc_fstate_e state;
	logic [7:0] volatile_settings;
	logic [7:0] settings_store;
	logic [7:0] cmd;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic [4:0] bitcnt;
	logic [3:0] dummy_left;
	logic [23:0] addr;
	logic [23:0] next_addr;
	logic [7:0] next_shreg;
	logic cmd_done;

	// Dummy count actually used: default code selects the command's own count
	function automatic logic [3:0] eff_dummy(input logic [7:0] s);
		if (s[`SFVC_DUMMY_MSB:`SFVC_DUMMY_LSB] == `SFVC_DUMMY_DEFAULT_CODE)
			return `SFVC_FAST_READ_DEFAULT_DUMMY; // [R3]
		return s[`SFVC_DUMMY_MSB:`SFVC_DUMMY_LSB]; // [R3]
	endfunction : eff_dummy

	// Next byte address with wrap inside an aligned block
	function automatic logic [23:0] wrap_inc(input logic [23:0] a, input logic [1:0] w);
		logic [23:0] inc;
		inc = a + 24'h000001;
		case (w)
			`SFVC_WRAP_16: return {a[23:4], inc[3:0]}; // [R5] [R7]
			`SFVC_WRAP_32: return {a[23:5], inc[4:0]}; // [R5] [R7]
			`SFVC_WRAP_64: return {a[23:6], inc[5:0]}; // [R5] [R7]
			default: return inc; // [R6]
		endcase
	endfunction : wrap_inc

	// Stand-in array byte
	function automatic logic [7:0] array_byte(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16];
	endfunction : array_byte

	assign next_shreg = {shreg[6:0], link.mosi};
	assign cmd_done = (bitcnt == 5'h07);
	assign next_addr = wrap_inc(addr, settings_store[`SFVC_WRAP_MSB:`SFVC_WRAP_LSB]);

	// ----------------------------------------
	// Command framing on the link clock
	// ----------------------------------------
	// Select high acts as frame reset; the host stops sck outside frames
	always_ff @(posedge link.sck or posedge link.cs_n or posedge i_rst)
	begin
		if (i_rst || link.cs_n)
		begin
			state <= SFVC_F_CMD;
			bitcnt <= 5'h00;
			shreg <= 8'h00;
			cmd <= 8'h00;
			addr <= 24'h000000;
			dummy_left <= 4'h0;
		end
		else
		begin
			shreg <= next_shreg;
			bitcnt <= bitcnt + 5'h01;
			case (state)
				SFVC_F_CMD:
				begin
					if (cmd_done)
					begin
						cmd <= next_shreg;
						bitcnt <= 5'h00;
						case (next_shreg)
							`SFVC_CMD_READ_VOL: state <= SFVC_F_RDATA; // [R1]
							`SFVC_CMD_WRITE_VOL: state <= SFVC_F_WDATA; // [R1]
							`SFVC_CMD_FAST_READ: state <= SFVC_F_ADDR;
							`SFVC_CMD_TUNING: state <= SFVC_F_RDATA; // [R12]
							default: state <= SFVC_F_IGNORE;
						endcase
					end
				end
				SFVC_F_ADDR:
				begin
					addr <= {addr[22:0], link.mosi};
					if (bitcnt == 5'h17)
					begin
						bitcnt <= 5'h00;
						dummy_left <= eff_dummy(settings_store);
						state <= SFVC_F_DUMMY;
					end
				end
				SFVC_F_DUMMY:
				begin
					// With too few dummies the host samples before data is ready [R9]
					bitcnt <= 5'h00;
					if (dummy_left <= 4'h1)
						state <= SFVC_F_RDATA;
					else
						dummy_left <= dummy_left - 4'h1;
				end
				SFVC_F_WDATA:
				begin
					// One data byte only; anything after it is ignored
					if (cmd_done)
					begin
						bitcnt <= 5'h00;
						state <= SFVC_F_IGNORE;
					end
				end
				SFVC_F_RDATA:
				begin
					if (cmd_done)
					begin
						bitcnt <= 5'h00;
						if (cmd == `SFVC_CMD_FAST_READ)
							addr <= next_addr; // [R7]
					end
				end
				default:
				begin
					bitcnt <= 5'h00;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Volatile settings register and store
	// ----------------------------------------
	// Register and store hold across frames; only the system reset reloads them
	always_ff @(posedge link.sck or posedge i_rst)
	begin
		if (i_rst)
			volatile_settings <= `SFVC_NONVOL_DEFAULT; // [R13]
		else if (!link.cs_n && state == SFVC_F_WDATA && cmd_done)
			volatile_settings <= next_shreg & `SFVC_RSVD_MASK; // [R1] [R14]
	end

	// Download happens when select rises after a settings command
	// cmd still holds the finished command here: the frame reset lands later
	always_ff @(posedge link.cs_n or posedge i_rst)
	begin
		if (i_rst)
			settings_store <= `SFVC_NONVOL_DEFAULT; // [R13]
		else if (cmd == `SFVC_CMD_WRITE_VOL || cmd == `SFVC_CMD_READ_VOL)
			settings_store <= volatile_settings; // [R2]
	end

	// ----------------------------------------
	// Output data, launched on falling sck
	// ----------------------------------------
	// Falling-edge launch gives the host a settled bit at the next rise
	always_ff @(negedge link.sck or posedge link.cs_n or posedge i_rst)
	begin
		if (i_rst || link.cs_n)
			tx <= 8'h00;
		else if (state == SFVC_F_RDATA && bitcnt == 5'h00)
		begin
			case (cmd)
				`SFVC_CMD_READ_VOL: tx <= volatile_settings & `SFVC_RSVD_MASK; // [R1] [R14]
				`SFVC_CMD_TUNING: tx <= `SFVC_TUNING_PATTERN; // [R12]
				default: tx <= array_byte(addr);
			endcase
		end
		else
			tx <= {tx[6:0], 1'b0};
	end

	// ----------------------------------------
	// Link outputs and status
	// ----------------------------------------
	// Settings and execute in place follow the store, so they only move at a frame end or on reset
	assign link.miso = tx[7];
	assign link.miso_oe = !link.cs_n && state == SFVC_F_RDATA;
	assign o_settings = settings_store;
	assign o_execute_in_place = !settings_store[`SFVC_XIP_BIT]; // [R4]
	assign o_store_loaded = (settings_store == volatile_settings);
endmodule : sfvc_flash

// [dv/sfvc_link_sva.sv]
// Purpose: Checks on the link between the host end and the flash end
// Assumes: sck is made from i_clock by a divider
// Notes: All checks sample on i_clock
`timescale 1ns/100ps
module sfvc_link_sva (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	// Flash status
	input wire logic [7:0] o_settings,
	input wire logic o_execute_in_place
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	logic [3:0] rises;

	// Rising sck edges in a frame; saturates so long reads stay past the command
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			rises <= 4'h0;
		else if (cs_n)
			rises <= 4'h0;
		else if ($rose(sck) && rises != 4'hF)
			rises <= rises + 4'h1;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_SCK_IDLE: assert property (cs_n |-> !sck)
		else $error("sck active outside a frame");
	AST_SCK_HALF: assert property ($changed(sck) |=> $stable(sck))
		else $error("sck half period too short");
	AST_CS_GAP: assert property ($rose(cs_n) |=> cs_n)
		else $error("no gap between frames");
	AST_OE_SELECTED: assert property (miso_oe |-> !cs_n)
		else $error("miso driven while deselected");
	AST_CMD_NO_OE: assert property ((!cs_n && (rises < 4'h7 || (rises == 4'h7 && !$rose(sck))))
		|-> !miso_oe)
		else $error("miso driven during command byte");
	AST_MOSI_HOLD: assert property (sck |-> $stable(mosi))
		else $error("mosi moved while sck high");
	AST_MISO_HOLD: assert property ((sck && miso_oe && $past(miso_oe)) |-> $stable(miso))
		else $error("miso moved while sck high");
	AST_RSVD_ZERO: assert property (o_settings[2] == 1'b0)
		else $error("reserved settings bit set");
	AST_XIP_FOLLOWS: assert property (o_execute_in_place == !o_settings[3])
		else $error("execute in place not tied to bit 3");
	AST_STORE_AT_END: assert property ($changed(o_settings) |-> cs_n)
		else $error("settings store moved inside a frame");
	AST_RESET_RELOAD: assert property ($fell(i_rst) |-> o_settings == 8'hFB)
		else $error("settings not reloaded by reset");

	// Main scenarios reached
	COV_FLASH_DRIVES: cover property (!cs_n && miso_oe);
	COV_STORE_MOVES: cover property ($changed(o_settings));
	COV_XIP_ON: cover property (o_execute_in_place);
endmodule : sfvc_link_sva

// [dv/tb.sv]
// Purpose: Self-checking bench for the host and flash ends joined by the link
// Assumes: Array content unknown, so wrapped reads are judged against a plain read
// Notes: Readback stalls the buffer only on the long 65-byte read
`timescale 1ns/100ps
`include "sfvc_cfg.svh"
module tb;
	logic i_clock = 1'b0;
	logic i_rst = 1'b0;
	logic i_req_valid = 1'b0;
	logic i_rd_ready = 1'b0;
	sfvc_pkg::sfvc_op_e i_req_op = sfvc_pkg::SFVC_OP_READ_VOL;
	logic [23:0] i_req_addr = 24'h000000;
	logic [7:0] i_req_data = 8'h00;
	logic [7:0] i_req_len = 8'h00;
	logic [7:0] o_rd_data;
	logic [7:0] o_settings;
	logic o_req_ready;
	logic o_rd_valid;
	logic o_execute_in_place;
	logic o_store_loaded;
	logic [7:0] rx [0:79];
	logic [7:0] plain [0:79];
	int n_errors = 0;
	int tests_run = 0;

	sfvc_link_if link ();
	sfvc_host sfvc_host_i (.i_clock(i_clock), .i_rst(i_rst), .i_req_valid(i_req_valid),
		.o_req_ready(o_req_ready), .i_req_op(i_req_op), .i_req_addr(i_req_addr),
		.i_req_data(i_req_data), .i_req_len(i_req_len), .o_rd_valid(o_rd_valid),
		.i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data), .link(link.host));
	sfvc_flash sfvc_flash_i (.link(link.flash), .i_rst(i_rst), .o_settings(o_settings),
		.o_execute_in_place(o_execute_in_place), .o_store_loaded(o_store_loaded));
	sfvc_link_sva sfvc_link_sva_i (.i_clock(i_clock), .i_rst(i_rst), .sck(link.sck),
		.cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
		.o_settings(o_settings), .o_execute_in_place(o_execute_in_place));

	// 10 MHz system clock
	always #50 i_clock = ~i_clock;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task end_sim;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask : chk

	// One request, then nb bytes; ready is withheld for stall cycles to fill the buffer
	task xfer(input sfvc_pkg::sfvc_op_e op, input logic [23:0] a, input logic [7:0] d,
		input logic [7:0] len, input int nb, input int stall);
		int k;
		int t;
		logic rdy;
		k = 0;
		t = 0;
		rdy = 1'b0;
		i_req_op = op;
		i_req_addr = a;
		i_req_data = d;
		i_req_len = len;
		i_req_valid = 1'b1;
		// Ready is sampled at the falling edge, where nothing moves
		while (!rdy && t < 500)
		begin
			@(negedge i_clock);
			rdy = o_req_ready;
			@(posedge i_clock);
			#1;
			t++;
		end
		i_req_valid = 1'b0;
		t = 0;
		while (k < nb && t < 4000)
		begin
			i_rd_ready = (t > stall) && (t % 3 == 0);
			@(negedge i_clock);
			if (o_rd_valid === 1'b1 && i_rd_ready)
			begin
				rx[k] = o_rd_data;
				k++;
			end
			@(posedge i_clock);
			#1;
			t++;
		end
		i_rd_ready = 1'b0;
		if (!rdy || t >= 4000)
		begin
			$display("FAIL t=%0t timeout got=%h exp=%h", $time, k, nb);
			n_errors++;
			end_sim();
		end
	endtask : xfer

	// Program wrap code w, read from start, judge the last two bytes
	task wrap_case(input logic [1:0] w, input logic [23:0] s, input logic [7:0] len,
		input int e_prev, input int e_last);
		xfer(sfvc_pkg::SFVC_OP_WRITE_VOL, 24'h0, {(w == 2'h3) ? 4'hF : 4'h8, 2'b10, w},
			8'h00, 0, 0);
		xfer(sfvc_pkg::SFVC_OP_FAST_READ, s, 8'h00, len, len + 1, 0);
		chk(rx[len - 1], plain[e_prev]);
		chk(rx[len], plain[e_last]);
	endtask : wrap_case

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		// Reset rises after time zero so every asynchronous reset sees an edge
		#1;
		i_rst = 1'b1;
		repeat (5) @(posedge i_clock);
		#1;
		i_rst = 1'b0;
		chk(o_settings, `SFVC_NONVOL_DEFAULT);
		chk({7'h00, o_execute_in_place}, 8'h00);
		xfer(sfvc_pkg::SFVC_OP_READ_VOL, 24'h0, 8'h00, 8'h00, 1, 0);
		chk(rx[0], 8'hFB);
		// Long stall first: the buffer fills and the link must wait, losing nothing
		xfer(sfvc_pkg::SFVC_OP_FAST_READ, 24'h0, 8'h00, 8'h40, 65, 300);
		for (int i = 0; i < 65; i++)
			plain[i] = rx[i];
		// Reserved bit written as 1, execute in place enabled
		xfer(sfvc_pkg::SFVC_OP_WRITE_VOL, 24'h0, 8'h84, 8'h00, 0, 0);
		xfer(sfvc_pkg::SFVC_OP_READ_VOL, 24'h0, 8'h00, 8'h00, 1, 0);
		chk(rx[0], 8'h80);
		chk(o_settings, 8'h80);
		chk({7'h00, o_execute_in_place}, 8'h01);
		wrap_case(2'h0, 24'h00000F, 8'h01, 15, 0);
		wrap_case(2'h1, 24'h00000F, 8'h11, 31, 0);
		wrap_case(2'h2, 24'h00003F, 8'h01, 63, 0);
		wrap_case(2'h3, 24'h00000F, 8'h01, 15, 16);
		xfer(sfvc_pkg::SFVC_OP_TUNING, 24'h0, 8'h00, 8'h00, 1, 0);
		chk(rx[0], `SFVC_TUNING_PATTERN);
		// Reset in mid-run drops the volatile change
		xfer(sfvc_pkg::SFVC_OP_WRITE_VOL, 24'h0, 8'h84, 8'h00, 0, 0);
		// Confirm the change landed, so the reset below has something to undo
		xfer(sfvc_pkg::SFVC_OP_READ_VOL, 24'h0, 8'h00, 8'h00, 1, 0);
		chk(rx[0], 8'h80);
		chk(o_settings, 8'h80);
		chk({7'h00, o_store_loaded}, 8'h01);
		i_rst = 1'b1;
		repeat (5) @(posedge i_clock);
		#1;
		i_rst = 1'b0;
		chk(o_settings, 8'hFB);
		xfer(sfvc_pkg::SFVC_OP_READ_VOL, 24'h0, 8'h00, 8'h00, 1, 0);
		chk(rx[0], 8'hFB);
		end_sim();
	end
endmodule : tb
